// file: design/qie_pkg.sv
// package: register map, event layout and bus types for the irq block
package qie_pkg;

  // register byte offsets
  localparam logic [11:0] QIE_OFS_ENSET   = 12'h304;
  localparam logic [11:0] QIE_OFS_ENCLR   = 12'h308;
  localparam logic [11:0] QIE_OFS_STATUS  = 12'h30C;
  localparam logic [11:0] QIE_OFS_MASK    = 12'h310;
  localparam logic [11:0] QIE_OFS_PERIOD  = 12'h314;

  // event bit positions
  localparam int QIE_EV_SAMPLE  = 0;
  localparam int QIE_EV_REPORT  = 1;
  localparam int QIE_EV_ACCUMULATOR_OVERFLOW_EVENT   = 2;
  localparam int QIE_EV_DOUBLE  = 3;
  localparam int QIE_EV_STOPPED = 4;
  localparam int QIE_NUM_EV     = 5;

  // reset values
  localparam logic [4:0]  QIE_ENABLE_RST = 5'h00;
  localparam logic [4:0]  QIE_STATUS_RST = 5'h00;
  localparam logic [4:0]  QIE_MASK_RST   = 5'h1F;
  localparam logic [15:0] QIE_PERIOD_RST = 16'h000A;

  // ahb encodings
  localparam logic [1:0] QIE_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] QIE_HTRANS_SEQ    = 2'h3;

  // raw decoder inputs that travel together
  typedef struct packed {
    logic sample_tick;   // one new sample taken
    logic motion_nz;     // motion accumulator nonzero
    logic double_nz;     // double-transition accumulator nonzero
    logic acc_overflow;  // accumulator overflowed
    logic stopped;       // decoder stopped
    logic period_clear;  // accumulators cleared, restart period
  } qie_dec_t;

  // latched ahb address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } qie_aph_t;

endpackage : qie_pkg

// file: design/qie_ev_bit.sv
`timescale 1ns/1ps
// one event: sticky status bit with enable set/clear
module qie_ev_bit
  import qie_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic event_in,
  input  wire logic en_set,
  input  wire logic en_clr,
  input  wire logic st_clr,
  output logic      enable_q,
  output logic      status_q
);

  // enable: set wins if both written in one cycle is impossible (one reg)
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      enable_q <= 1'b0;
    else if (ce)
    begin
      if (en_set)
        enable_q <= 1'b1;
      else if (en_clr)
        enable_q <= 1'b0;
    end
  end

  // sticky status, a new event beats the read-clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_q <= 1'b0;
    else if (ce)
    begin
      if (event_in && enable_q)
        status_q <= 1'b1;
      else if (st_clr)
        status_q <= 1'b0;
    end
  end

endmodule : qie_ev_bit

// file: design/qie_sync3.sv
`timescale 1ns/1ps
// three-flop synchroniser, change accepted when stages two and three agree
module qie_sync3
  import qie_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // s1 feeds s2 only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      q      <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        q <= s3_reg;
    end
  end

endmodule : qie_sync3

// file: design/qie_top.sv
`timescale 1ns/1ps
// quadrature decoder interrupt enable block with ahb-lite register slave
module qie_top
  import qie_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire qie_dec_t    dec_in,
  output logic             irq
);

  qie_aph_t                aph_reg;
  logic [QIE_NUM_EV-1:0]   enable_q;
  logic [QIE_NUM_EV-1:0]   status_q;
  logic [QIE_NUM_EV-1:0]   mask_reg;
  logic [QIE_NUM_EV-1:0]   ev_raw;
  logic [QIE_NUM_EV-1:0]   en_set;
  logic [QIE_NUM_EV-1:0]   en_clr;
  logic                    st_clr;
  logic [15:0]             period_reg;
  logic [15:0]             sample_cnt_reg;
  logic                    period_done;
  logic                    wr_now;
  logic                    rd_take;
  logic [31:0]             rd_next;
  logic                    tick_s;
  logic                    tick_d_reg;
  logic                    motion_s;
  logic                    double_s;
  logic                    accumulator_overflow_event_s;
  logic                    accumulator_overflow_event_d_reg;
  logic                    stop_s;
  logic                    stop_d_reg;
  logic                    pclr_s;
  logic                    pclr_d_reg;

  // decoder pins come from outside the clock domain
  qie_sync3 u_s_tick (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .d(dec_in.sample_tick), .q(tick_s));
  qie_sync3 u_s_mot (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .d(dec_in.motion_nz), .q(motion_s));
  qie_sync3 u_s_dbl (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .d(dec_in.double_nz), .q(double_s));
  qie_sync3 u_s_of (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .d(dec_in.acc_overflow), .q(accumulator_overflow_event_s));
  qie_sync3 u_s_stop (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .d(dec_in.stopped), .q(stop_s));
  qie_sync3 u_s_pclr (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .d(dec_in.period_clear), .q(pclr_s));

  // edge history for the synchronised tick, overflow, stop and clear levels
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_d_reg  <= 1'b0;
      accumulator_overflow_event_d_reg <= 1'b0;
      stop_d_reg  <= 1'b0;
      pclr_d_reg  <= 1'b0;
    end
    else if (ce)
    begin
      tick_d_reg  <= tick_s;
      accumulator_overflow_event_d_reg <= accumulator_overflow_event_s;
      stop_d_reg  <= stop_s;
      pclr_d_reg  <= pclr_s;
    end
  end

  // samples counted toward the report period
  assign period_done = tick_s && !tick_d_reg &&
                       (sample_cnt_reg + 16'h0001 >= period_reg);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sample_cnt_reg <= 16'h0000;
    else if (ce)
    begin
      if (pclr_s && !pclr_d_reg)
        sample_cnt_reg <= 16'h0000;
      else if (period_done)
        sample_cnt_reg <= 16'h0000;
      else if (tick_s && !tick_d_reg)
        sample_cnt_reg <= sample_cnt_reg + 16'h0001;
    end
  end

  // raw event strobes
  always_comb
  begin
    ev_raw = '0;
    ev_raw[QIE_EV_SAMPLE]  = tick_s && !tick_d_reg;
    ev_raw[QIE_EV_REPORT]  = period_done && motion_s;
    ev_raw[QIE_EV_ACCUMULATOR_OVERFLOW_EVENT]   = accumulator_overflow_event_s && !accumulator_overflow_event_d_reg;
    ev_raw[QIE_EV_DOUBLE]  = period_done && double_s;
    ev_raw[QIE_EV_STOPPED] = stop_s && !stop_d_reg;
  end

  // ahb address phase capture; data phase always zero wait
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aph_reg <= '0;
    else if (ce && hready)
    begin
      aph_reg.valid <= hsel && (htrans == QIE_HTRANS_NONSEQ ||
                                htrans == QIE_HTRANS_SEQ);
      aph_reg.write <= hwrite;
      aph_reg.addr  <= haddr[11:0];
    end
  end

  assign wr_now  = ce && aph_reg.valid && aph_reg.write;
  assign rd_take = ce && hready && hsel && !hwrite &&
                   (htrans == QIE_HTRANS_NONSEQ || htrans == QIE_HTRANS_SEQ);

  // write decode to per-event strobes; zeros do nothing
  always_comb
  begin
    en_set = '0;
    en_clr = '0;
    if (wr_now && aph_reg.addr == QIE_OFS_ENSET)
      en_set = hwdata[QIE_NUM_EV-1:0];
    if (wr_now && aph_reg.addr == QIE_OFS_ENCLR)
      en_clr = hwdata[QIE_NUM_EV-1:0];
  end

  // status clears on read, evaluated in the address phase
  assign st_clr = rd_take && haddr[11:0] == QIE_OFS_STATUS;

  genvar gi;
  generate
    for (gi = 0; gi < QIE_NUM_EV; gi++)
    begin : g_ev
      qie_ev_bit u_bit (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .event_in (ev_raw[gi]),
        .en_set   (en_set[gi]),
        .en_clr   (en_clr[gi]),
        .st_clr   (st_clr),
        .enable_q (enable_q[gi]),
        .status_q (status_q[gi])
      );
    end
  endgenerate

  // mask and report period registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mask_reg   <= QIE_MASK_RST;
      period_reg <= QIE_PERIOD_RST;
    end
    else if (wr_now)
    begin
      if (aph_reg.addr == QIE_OFS_MASK)
        mask_reg <= hwdata[QIE_NUM_EV-1:0];
      if (aph_reg.addr == QIE_OFS_PERIOD)
        period_reg <= hwdata[15:0];
    end
  end

  // read mux; unmapped words read zero
  always_comb
  begin
    rd_next = 32'h0000_0000;
    case (haddr[11:0])
      QIE_OFS_ENSET:  rd_next[QIE_NUM_EV-1:0] = enable_q;
      QIE_OFS_ENCLR:  rd_next[QIE_NUM_EV-1:0] = enable_q;
      QIE_OFS_STATUS: rd_next[QIE_NUM_EV-1:0] = status_q;
      QIE_OFS_MASK:   rd_next[QIE_NUM_EV-1:0] = mask_reg;
      QIE_OFS_PERIOD: rd_next[15:0] = period_reg;
      default:        rd_next = 32'h0000_0000;
    endcase
  end

  // read data registered at the address-phase edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_take)
      hrdata <= rd_next;
  end

  // slave never stalls and always answers okay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(status_q & mask_reg);
  end

  // reference sample count, apart from the datapath counter on purpose
  logic [16:0]             ref_cnt_reg;
  logic                    ref_edge;
  logic                    ref_full;

  assign ref_edge = tick_s && !tick_d_reg;
  assign ref_full = ref_edge &&
                    (ref_cnt_reg + 17'h0_0001 >= {1'b0, period_reg});

  // one bit wider than the period, so the compare cannot wrap
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ref_cnt_reg <= 17'h0_0000;
    else if (ce)
    begin
      if ((pclr_s && !pclr_d_reg) || ref_full)
        ref_cnt_reg <= 17'h0_0000;
      else if (ref_edge)
        ref_cnt_reg <= ref_cnt_reg + 17'h0_0001;
    end
  end

  // named steps that the properties below are built from
  sequence s_clr_write;
    wr_now && aph_reg.addr == QIE_OFS_ENCLR;
  endsequence

  sequence s_set_write;
    wr_now && aph_reg.addr == QIE_OFS_ENSET;
  endsequence

  sequence s_report_cause;
    ref_full && motion_s;
  endsequence

  sequence s_double_cause;
    ref_full && double_s;
  endsequence

  // a clear write must drop the enable one cycle later
  a_clear_disables: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_clr_write |=> ((enable_q & $past(hwdata[QIE_NUM_EV-1:0])) == '0))
    else $error("enable bit survived a clear write");

  a_zero_keeps: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_clr_write ##0 !hwdata[0]) |=> enable_q[0] == $past(enable_q[0]))
    else $error("zero write changed an enable");

  a_set_enables: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (s_set_write ##0 hwdata[1]) |=> enable_q[1])
    else $error("set write did not enable");

  a_clr_readback: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (rd_take && haddr[11:0] == QIE_OFS_ENCLR)
      |=> hrdata[QIE_NUM_EV-1:0] == $past(enable_q))
    else $error("clear register readback wrong");

  // report and double events only from their causes, and always from them
  a_report_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev_raw[QIE_EV_REPORT] |-> s_report_cause)
    else $error("report event without cause");

  a_report_raised: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_report_cause |-> ev_raw[QIE_EV_REPORT])
    else $error("report cause without event");

  a_double_cause: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ev_raw[QIE_EV_DOUBLE] |-> s_double_cause)
    else $error("double event without cause");

  a_double_raised: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_double_cause |-> ev_raw[QIE_EV_DOUBLE])
    else $error("double cause without event");

  // a disabled report event must never reach its status bit
  a_disabled_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !enable_q[QIE_EV_REPORT] && !status_q[QIE_EV_REPORT] && !st_clr)
      |=> !status_q[QIE_EV_REPORT])
    else $error("disabled event set status");

  a_irq_follows: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce |=> irq == |($past(status_q) & $past(mask_reg)))
    else $error("irq does not follow status");

  // every event bit on its own, for clear and set alike
  generate
    for (gi = 0; gi < QIE_NUM_EV; gi++)
    begin : g_chk
      a_clear_bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_clr_write ##0 hwdata[gi]) |=> !enable_q[gi])
        else $error("clear bit left its enable on");

      a_zero_bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_clr_write ##0 !hwdata[gi])
          |=> enable_q[gi] == $past(enable_q[gi]))
        else $error("zero clear bit changed its enable");

      a_set_bit: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_set_write ##0 hwdata[gi]) |=> enable_q[gi])
        else $error("set bit left its enable off");
    end
  endgenerate

  // clock enable low freezes every register the bus can see
  a_ce_freeze: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ce |=> $stable(enable_q) && $stable(status_q) && $stable(mask_reg) &&
      $stable(period_reg) && $stable(irq) && $stable(hrdata))
    else $error("state moved while clock enable low");

endmodule : qie_top

// file: tb/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the quadrature interrupt enable block
module tb_top
  import qie_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  qie_dec_t    dec_in;
  int          fails;
  int          n_tests;
  int          cyc;

  // decoder input bit positions, msb first in the struct
  localparam int B_SMP = 5;
  localparam int B_MOT = 4;
  localparam int B_DBL = 3;
  localparam int B_STP = 1;
  localparam int B_CLR = 0;

  // single slave, so its ready is the bus ready
  qie_top dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'h2),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .dec_in    (dec_in),
    .irq       (irq)
  );

  // 200 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one ahb single transfer; ready and data taken at rising edges only
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, a};
    hwrite <= w;
    htrans <= QIE_HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input string nm);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk(nm, exp, r);
    chk("hresp", 32'h00000000, {31'h0, hresp});
  endtask : rd

  // inputs pass a synchroniser, so hold each level for a while
  task automatic pulse(input int idx);
    dec_in[idx] <= 1'b1;
    repeat (8) @(posedge hclk);
    dec_in[idx] <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : pulse

  // irq lags the status by a cycle, so let it settle first
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
    @(posedge hclk);
  endtask : chk_irq

  task automatic t_reset;
    rd(QIE_OFS_ENCLR, 32'h00000000, "enclr");
    rd(QIE_OFS_ENSET, 32'h00000000, "enset");
    rd(QIE_OFS_MASK, 32'h0000001F, "mask");
    rd(12'h400, 32'h00000000, "unmapped");
  endtask : t_reset

  // walk the clear bits one at a time from all enabled
  task automatic t_clear;
    logic [31:0] exp;
    wr(QIE_OFS_ENSET, 32'h0000001F);
    rd(QIE_OFS_ENCLR, 32'h0000001F, "enclr");
    wr(QIE_OFS_ENCLR, 32'h00000000);
    rd(QIE_OFS_ENCLR, 32'h0000001F, "enclr");
    exp = 32'h0000001F;
    for (int i = 0; i < 5; i++)
    begin
      wr(QIE_OFS_ENCLR, 32'h00000001 << i);
      exp &= ~(32'h00000001 << i);
      rd(QIE_OFS_ENCLR, exp, "enclr");
      rd(QIE_OFS_ENSET, exp, "enset");
    end
  endtask : t_clear

  task automatic t_irq;
    wr(QIE_OFS_ENSET, 32'h00000010);
    pulse(B_STP);
    chk_irq(1'b1);
    rd(QIE_OFS_STATUS, 32'h00000010, "status");
    chk_irq(1'b0);
    wr(QIE_OFS_MASK, 32'h00000000);
    pulse(B_STP);
    chk_irq(1'b0);
    rd(QIE_OFS_STATUS, 32'h00000010, "status");
    wr(QIE_OFS_MASK, 32'h0000001F);
    wr(QIE_OFS_ENCLR, 32'h00000010);
    pulse(B_STP);
    rd(QIE_OFS_STATUS, 32'h00000000, "status");
    chk_irq(1'b0);
  endtask : t_irq

  // period of two samples, motion then doubles
  task automatic t_report;
    wr(QIE_OFS_PERIOD, 32'h00000002);
    wr(QIE_OFS_ENSET, 32'h0000000A);
    dec_in[B_MOT] <= 1'b1;
    pulse(B_CLR);
    pulse(B_SMP);
    rd(QIE_OFS_STATUS, 32'h00000000, "status");
    pulse(B_SMP);
    rd(QIE_OFS_STATUS, 32'h00000002, "status");
    dec_in[B_MOT] <= 1'b0;
    dec_in[B_DBL] <= 1'b1;
    pulse(B_SMP);
    rd(QIE_OFS_STATUS, 32'h00000000, "status");
    pulse(B_SMP);
    rd(QIE_OFS_STATUS, 32'h00000008, "status");
  endtask : t_report

  // clock enable low: a set write must not land
  task automatic t_freeze;
    ce <= 1'b0;
    wr(QIE_OFS_ENSET, 32'h00000001);
    ce <= 1'b1;
    rd(QIE_OFS_ENCLR, 32'h0000000A, "enclr");
  endtask : t_freeze

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // hang guard, far above the few hundred cycles needed
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      results();
    end
  end

  // main sequence
  initial
  begin
    fails   = 0;
    n_tests = 0;
    cyc     = 0;
    hresetn = 1'b0;
    ce      = 1'b1;
    hsel    = 1'b0;
    hwrite  = 1'b0;
    haddr   = 32'h00000000;
    hwdata  = 32'h00000000;
    htrans  = 2'h0;
    dec_in  = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_clear();
    t_irq();
    t_report();
    t_freeze();
    results();
  end
endmodule : tb_top
